/* File: hw/plc_access.sv */
`timescale 1ns/1ps
module plc_access
  import plc_pkg::*;
(
  // request and context
  input  wire plc_req_t     req,
  input  wire plc_ctx_t     ctx,
  // configuration
  input  wire logic         have_el3,
  input  wire logic         virt_support,
  input  wire logic         force_lower_trap,
  // decision
  output logic              hit_top,
  output logic              hit_hyp,
  output plc_outcome_t      outcome,
  output plc_el_t           target_el
);

  // forced trap to the top level, or undefined when halted with secure debug off
  function automatic plc_outcome_t lower_trap(input logic halted, input logic secure_debug_disable);
    lower_trap = (halted && secure_debug_disable) ? PLC_ACC_UNDEF : PLC_ACC_TRAP;
  endfunction : lower_trap

  wire common_hit = req.valid && (req.op0 == PLC_OP0_SYS) && (req.crn == PLC_CRN_LBL)
                    && (req.op2 == PLC_OP2_REG);
  wire forced     = have_el3 && force_lower_trap;
  wire nv_on      = ctx.el2_enabled && ctx.nv;

  assign hit_top = common_hit && (req.op1 == PLC_OP1_TOP) && (req.crm == PLC_CRM_TOP);
  assign hit_hyp = common_hit && (req.op1 == PLC_OP1_HYP) && (req.crm == PLC_CRM_HYP);

  always_comb begin
    outcome   = PLC_ACC_NONE;
    target_el = PLC_EL3;
    if (hit_top) begin
      outcome = (req.el == PLC_EL3) ? PLC_ACC_DONE : PLC_ACC_UNDEF;
    end else if (hit_hyp) begin
      if (!virt_support) begin
        outcome = PLC_ACC_UNDEF;
      end else begin
        unique case (req.el)
          PLC_EL0: outcome = PLC_ACC_UNDEF;
          PLC_EL1: begin
            if (nv_on && ctx.nv2) begin
              outcome = PLC_ACC_NVMEM;
            end else if (nv_on) begin
              outcome   = forced ? lower_trap(ctx.halted, ctx.secure_debug_disable) : PLC_ACC_TRAP;
              target_el = forced ? PLC_EL3 : PLC_EL2;
            end else begin
              outcome = PLC_ACC_UNDEF;
            end
          end
          PLC_EL2: outcome = forced ? lower_trap(ctx.halted, ctx.secure_debug_disable) : PLC_ACC_DONE;
          PLC_EL3: outcome = PLC_ACC_DONE;
        endcase
      end
    end
  end

endmodule : plc_access

/* File: hw/plc_pkg.sv */
package plc_pkg;

  // field positions, top-level label register
  localparam int PLC_FORCE_TRAP_BIT = 62;
  localparam int PLC_ALT_SEL_BIT    = 55;
  localparam int PLC_ROOT_NS_BIT    = 52;
  localparam int PLC_DMG_LSB        = 40;
  localparam int PLC_IMG_LSB        = 32;
  localparam int PLC_DPID_LSB       = 16;
  localparam int PLC_IPID_LSB       = 0;
  localparam int PLC_MG_W           = 8;
  localparam int PLC_PID_W          = 16;

  // field positions, hypervisor label control
  localparam int PLC_ID_TRAP_BIT    = 31;
  localparam int PLC_SHARE_BIT      = 8;
  localparam int PLC_L1MAP_BIT      = 1;
  localparam int PLC_L0MAP_BIT      = 0;

  // implemented bits; everything else reads zero and drops writes
  localparam logic [63:0] PLC_TOP_MASK = 64'h4090_FFFF_FFFF_FFFF;
  localparam logic [63:0] PLC_HYP_MASK = 64'h0000_0000_8000_0103;

  // reset values; alt-space bits are an implementation choice
  localparam logic        PLC_ALT_SEL_RST    = 1'h0;
  localparam logic        PLC_ROOT_NS_RST    = 1'h0;
  localparam logic        PLC_FORCE_TRAP_RST = 1'h1;
  localparam logic        PLC_ID_TRAP_RST    = 1'h1;
  localparam logic [63:0] PLC_TOP_RST =
    (64'(PLC_FORCE_TRAP_RST) << PLC_FORCE_TRAP_BIT) |
    (64'(PLC_ALT_SEL_RST) << PLC_ALT_SEL_BIT) |
    (64'(PLC_ROOT_NS_RST) << PLC_ROOT_NS_BIT);
  localparam logic [63:0] PLC_HYP_RST = 64'(PLC_ID_TRAP_RST) << PLC_ID_TRAP_BIT;

  // system register encodings
  localparam logic [1:0] PLC_OP0_SYS = 2'h3;
  localparam logic [3:0] PLC_CRN_LBL = 4'hA;
  localparam logic [2:0] PLC_OP2_REG = 3'h0;
  localparam logic [2:0] PLC_OP1_TOP = 3'h6;
  localparam logic [3:0] PLC_CRM_TOP = 4'h5;
  localparam logic [2:0] PLC_OP1_HYP = 3'h4;
  localparam logic [3:0] PLC_CRM_HYP = 4'h4;

  localparam logic [5:0]  PLC_SYNDROME = 6'h18;
  localparam logic [11:0] PLC_NV_ADDR  = 12'h930;

  typedef enum logic [1:0] {
    PLC_EL0 = 2'h0,
    PLC_EL1 = 2'h1,
    PLC_EL2 = 2'h2,
    PLC_EL3 = 2'h3
  } plc_el_t;

  typedef enum logic [2:0] {
    PLC_ACC_NONE  = 3'h0,
    PLC_ACC_DONE  = 3'h1,
    PLC_ACC_UNDEF = 3'h2,
    PLC_ACC_TRAP  = 3'h3,
    PLC_ACC_NVMEM = 3'h4
  } plc_outcome_t;

  typedef enum logic [1:0] {
    PLC_SPACE_PRIMARY   = 2'h0,
    PLC_SPACE_ALT       = 2'h1,
    PLC_SPACE_ALT_SEC   = 2'h2,
    PLC_SPACE_ALT_NSEC  = 2'h3
  } plc_space_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    plc_el_t     el;
    logic [1:0]  op0;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    logic [63:0] wdata;
  } plc_req_t;

  typedef struct packed {
    logic el2_enabled;
    logic root_state;
    logic trap_general_exceptions;
    logic e2h;
    logic nv;
    logic nv2;
    logic halted;
    logic secure_debug_disable;
  } plc_ctx_t;

  typedef struct packed {
    logic         valid;
    plc_outcome_t outcome;
    plc_el_t      target_el;
    logic [5:0]   syndrome;
    logic [11:0]  nv_addr;
    logic [63:0]  rdata;
  } plc_resp_t;

  typedef struct packed {
    plc_space_t            space;
    logic [PLC_MG_W-1:0]   data_monitor_group;
    logic [PLC_MG_W-1:0]   instr_monitor_group;
    logic [PLC_PID_W-1:0]  data_partition_id;
    logic [PLC_PID_W-1:0]  instr_partition_id;
  } plc_label_t;

  typedef struct packed {
    logic el0_from_level1;
    logic level1_map;
    logic level0_map;
    logic id_reg_trap;
  } plc_steer_t;

endpackage : plc_pkg

/* File: hw/plc_regs.sv */
`timescale 1ns/1ps
// Behaviour
// - alt select bit picks primary/alternative top space
// - root alt bit: 0 secure, 1 non-secure
// - root alt bit matters only in root state
// - top label fields at documented bit positions
// - labels follow register writes, nothing cached
// - top register accessible only at top level
// - hypervisor controls need virtualization and level-2
// - id trap bit traps level-1 id reads
// - id trap bit resets to one
// - label sharing: level-0 uses level-1 register
// - bit 1 maps level-1 partition ids
// - bit 0 maps level-0 ids unless label sharing is in effect or host+tge
// - level-1 hypervisor access: redirect, trap or undefined
// - level-2 hypervisor access: trap, undefined or perform
// - force-lower-trap bit sends lower accesses up
module plc_regs
  import plc_pkg::*;
(
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  // configuration straps
  input  wire logic       HAVE_EL3,
  input  wire logic       VIRT_SUPPORT_FLAG,
  // system register access
  input  wire plc_req_t   SYSREG_REQ,
  output plc_resp_t       SYSREG_RESP,
  // execution context
  input  wire plc_ctx_t   CTX,
  input  wire plc_el_t    CUR_EL,
  // labels and steering towards the memory system
  output plc_label_t      TOP_LABEL,
  output plc_steer_t      STEER,
  output logic            FORCE_LOWER_TRAP
);

  logic [63:0]  top_reg;
  logic [63:0]  top_next;
  logic [63:0]  hyp_reg;
  logic [63:0]  hyp_next;
  plc_resp_t    resp_reg;
  plc_resp_t    resp_next;
  plc_label_t   label_reg;
  plc_label_t   label_next;
  plc_steer_t   steer_reg;
  plc_steer_t   steer_next;
  logic         hit_top;
  logic         hit_hyp;
  plc_outcome_t outcome;
  plc_el_t      target_el;

  plc_access u_access (
    .req              (SYSREG_REQ),
    .ctx              (CTX),
    .have_el3         (HAVE_EL3),
    .virt_support     (VIRT_SUPPORT_FLAG),
    .force_lower_trap (top_reg[PLC_FORCE_TRAP_BIT]),
    .hit_top          (hit_top),
    .hit_hyp          (hit_hyp),
    .outcome          (outcome),
    .target_el        (target_el)
  );

  // register writes
  wire do_write = SYSREG_REQ.write && (outcome == PLC_ACC_DONE);
  wire wr_top   = do_write && hit_top;
  wire wr_hyp   = do_write && hit_hyp;

  assign top_next = wr_top ? (SYSREG_REQ.wdata & PLC_TOP_MASK) : top_reg;
  assign hyp_next = wr_hyp ? (SYSREG_REQ.wdata & PLC_HYP_MASK) : hyp_reg;

  // field views
  wire alt_sel   = top_reg[PLC_ALT_SEL_BIT];
  wire root_ns   = top_reg[PLC_ROOT_NS_BIT];
  wire id_trap   = hyp_reg[PLC_ID_TRAP_BIT];
  wire share     = hyp_reg[PLC_SHARE_BIT];
  wire l1map_en  = hyp_reg[PLC_L1MAP_BIT];
  wire l0map_en  = hyp_reg[PLC_L0MAP_BIT];

  // hypervisor controls are dead unless both implemented and enabled here
  wire hyp_live  = VIRT_SUPPORT_FLAG && CTX.el2_enabled;
  wire at_el0    = (CUR_EL == PLC_EL0);
  wire at_el1    = (CUR_EL == PLC_EL1);
  wire root_top  = CTX.root_state && (CUR_EL == PLC_EL3);

  // label space of the top level
  wire plc_space_t space_sel =
    !alt_sel ? PLC_SPACE_PRIMARY :
    !root_top ? PLC_SPACE_ALT :
    root_ns ? PLC_SPACE_ALT_NSEC : PLC_SPACE_ALT_SEC;

  always_comb begin
    label_next                     = label_reg;
    label_next.space               = space_sel;
    // fields read from the register and held in label_reg, so a write shows one cycle after the register takes it
    label_next.data_monitor_group  = top_reg[PLC_DMG_LSB +: PLC_MG_W];
    label_next.instr_monitor_group = top_reg[PLC_IMG_LSB +: PLC_MG_W];
    label_next.data_partition_id   = top_reg[PLC_DPID_LSB +: PLC_PID_W];
    label_next.instr_partition_id  = top_reg[PLC_IPID_LSB +: PLC_PID_W];
  end

  wire el0_l1 = hyp_live && !CTX.trap_general_exceptions && share && at_el0;

  always_comb begin
    steer_next                 = steer_reg;
    steer_next.el0_from_level1 = el0_l1;
    steer_next.level1_map      = hyp_live && l1map_en && (at_el1 || el0_l1);
    steer_next.level0_map      = hyp_live && l0map_en && at_el0 && !el0_l1
                                 && !(CTX.e2h && CTX.trap_general_exceptions);
    steer_next.id_reg_trap     = hyp_live && id_trap;
  end

  // answer one cycle after the request
  always_comb begin
    resp_next           = '0;
    resp_next.valid     = SYSREG_REQ.valid;
    resp_next.outcome   = outcome;
    resp_next.target_el = target_el;
    if (outcome == PLC_ACC_TRAP) begin
      resp_next.syndrome = PLC_SYNDROME;
    end
    if (outcome == PLC_ACC_NVMEM) begin
      resp_next.nv_addr = PLC_NV_ADDR;
    end
    if (outcome == PLC_ACC_DONE && !SYSREG_REQ.write) begin
      resp_next.rdata = hit_top ? top_reg : hyp_reg;
    end
  end

  // unknown-reset fields take the same constants; any value is legal there
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      top_reg   <= PLC_TOP_RST;
      hyp_reg   <= PLC_HYP_RST;
      resp_reg  <= '0;
      label_reg <= '0;
      steer_reg <= '0;
    end else begin
      top_reg   <= top_next;
      hyp_reg   <= hyp_next;
      resp_reg  <= resp_next;
      label_reg <= label_next;
      steer_reg <= steer_next;
    end
  end

  assign SYSREG_RESP      = resp_reg;
  assign TOP_LABEL        = label_reg;
  assign STEER            = steer_reg;
  assign FORCE_LOWER_TRAP = HAVE_EL3 && top_reg[PLC_FORCE_TRAP_BIT];

endmodule : plc_regs

/* File: tb/plc_mem_sink.sv */
`timescale 1ns/1ps
module plc_mem_sink
  import plc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire plc_label_t label,
  input  wire plc_steer_t steer,
  output logic            changed
);
  plc_label_t last_reg;
  // memory side notes label changes and any set steer bit; it never pushes back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= '0;
      changed  <= 1'b0;
    end else begin
      last_reg <= label;
      changed  <= (label != last_reg) || (|steer);
    end
  end
endmodule : plc_mem_sink

/* File: tb/plc_regs_chk.sv */
`timescale 1ns/1ps
module plc_regs_chk
  import plc_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       NRST,
  input wire logic       HAVE_EL3,
  input wire logic       VIRT_SUPPORT_FLAG,
  input wire plc_req_t   SYSREG_REQ,
  input wire plc_resp_t  SYSREG_RESP,
  input wire plc_ctx_t   CTX,
  input wire plc_el_t    CUR_EL,
  input wire plc_label_t TOP_LABEL,
  input wire plc_steer_t STEER,
  input wire logic       FORCE_LOWER_TRAP
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  wire enc     = SYSREG_REQ.valid && SYSREG_REQ.op0 == PLC_OP0_SYS
                 && SYSREG_REQ.crn == PLC_CRN_LBL && SYSREG_REQ.op2 == PLC_OP2_REG;
  wire top_hit = enc && SYSREG_REQ.op1 == PLC_OP1_TOP && SYSREG_REQ.crm == PLC_CRM_TOP;
  wire hyp_hit = enc && SYSREG_REQ.op1 == PLC_OP1_HYP && SYSREG_REQ.crm == PLC_CRM_HYP
                 && VIRT_SUPPORT_FLAG;
  AST_RESP: assert property (SYSREG_REQ.valid |=> SYSREG_RESP.valid)
    else $error("no answer one cycle after request");
  AST_TOP_UNDEF: assert property (top_hit && SYSREG_REQ.el != PLC_EL3
    |=> SYSREG_RESP.outcome == PLC_ACC_UNDEF) else $error("lower top access not undefined");
  AST_NV: assert property (hyp_hit && SYSREG_REQ.el == PLC_EL1 && CTX.el2_enabled
    && CTX.nv && CTX.nv2 |=> SYSREG_RESP.outcome == PLC_ACC_NVMEM
    && SYSREG_RESP.nv_addr == PLC_NV_ADDR) else $error("nested redirect wrong");
  AST_SYN: assert property (SYSREG_RESP.valid && SYSREG_RESP.outcome == PLC_ACC_TRAP
    |-> SYSREG_RESP.syndrome == PLC_SYNDROME) else $error("trap syndrome wrong");
  AST_LOWER: assert property (hyp_hit && SYSREG_REQ.el == PLC_EL2 && FORCE_LOWER_TRAP
    && !(CTX.halted && CTX.secure_debug_disable) |=> SYSREG_RESP.outcome == PLC_ACC_TRAP
    && SYSREG_RESP.target_el == PLC_EL3) else $error("lower access not sent up");
  AST_LIVE: assert property (STEER.id_reg_trap
    |-> $past(VIRT_SUPPORT_FLAG && CTX.el2_enabled)) else $error("steer without level two");
  AST_ROOT: assert property (TOP_LABEL.space == PLC_SPACE_ALT_NSEC
    |-> $past(CTX.root_state && CUR_EL == PLC_EL3)) else $error("root space outside root");
  AST_L0MAP: assert property (STEER.level0_map
    |-> !$past(CTX.e2h && CTX.trap_general_exceptions)) else $error("level0 mapped under host");
  AST_SHARE: assert property (STEER.el0_from_level1
    |-> $past(!CTX.trap_general_exceptions && CUR_EL == PLC_EL0)) else $error("sharing in wrong state");
endmodule : plc_regs_chk
bind plc_regs plc_regs_chk plc_regs_chk_i (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .HAVE_EL3(HAVE_EL3), .VIRT_SUPPORT_FLAG(VIRT_SUPPORT_FLAG), .SYSREG_REQ(SYSREG_REQ),
  .SYSREG_RESP(SYSREG_RESP), .CTX(CTX), .CUR_EL(CUR_EL), .TOP_LABEL(TOP_LABEL),
  .STEER(STEER), .FORCE_LOWER_TRAP(FORCE_LOWER_TRAP));

/* File: tb/tb_plc_regs.sv */
`timescale 1ns/1ps
module tb_plc_regs;
  import plc_pkg::*;
  logic        CORE_CLK = 0, NRST = 0, HAVE_EL3 = 1, VIRT_SUPPORT_FLAG = 1, flt, sink_chg;
  plc_req_t    req = '0;
  plc_ctx_t    ctx = '0;
  plc_el_t     cur_el = PLC_EL3;
  plc_resp_t   resp;
  plc_label_t  lbl;
  plc_steer_t  steer;
  plc_resp_t   expq[$];
  logic [63:0] d;
  int          num_errors = 0, samples_checked = 0, cyc = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  plc_regs plc_regs_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .HAVE_EL3(HAVE_EL3),
    .VIRT_SUPPORT_FLAG(VIRT_SUPPORT_FLAG), .SYSREG_REQ(req), .SYSREG_RESP(resp), .CTX(ctx),
    .CUR_EL(cur_el), .TOP_LABEL(lbl), .STEER(steer), .FORCE_LOWER_TRAP(flt));
  plc_mem_sink plc_mem_sink_i (.clk(CORE_CLK), .rst_n(NRST), .label(lbl), .steer(steer),
    .changed(sink_chg));
  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic check(string n, logic [63:0] seen, logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp=%h seen=%h", n, exp, seen);
    end
  endtask : check
  // read data is only compared when the note asks for it (valid bit reused)
  task automatic acc(plc_el_t el, bit top, bit wr, logic [63:0] wd, plc_outcome_t oc,
                     plc_el_t tgt, bit chk);
    plc_resp_t e;
    @(negedge CORE_CLK);
    req = '{1'b1, wr, el, PLC_OP0_SYS, top ? PLC_OP1_TOP : PLC_OP1_HYP, PLC_CRN_LBL,
            top ? PLC_CRM_TOP : PLC_CRM_HYP, PLC_OP2_REG, wd};
    e = '{chk, oc, tgt, 6'h0, 12'h0, wd};
    expq.push_back(e);
    @(negedge CORE_CLK);
    req.valid = 1'b0;
  endtask : acc
  always @(posedge CORE_CLK) begin : mon
    plc_resp_t e;
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      final_report();
    end else if (resp.valid === 1'b1) begin
      if (expq.size() == 0) check("spurious", 64'h1, 64'h0);
      else begin
        e = expq.pop_front();
        check("outcome", 64'(resp.outcome), 64'(e.outcome));
        if (e.outcome == PLC_ACC_TRAP) begin
          check("target", 64'(resp.target_el), 64'(e.target_el));
          check("syndrome", 64'(resp.syndrome), 64'(PLC_SYNDROME));
        end
        if (e.valid) check("rdata", resp.rdata, e.rdata);
      end
    end
  end
  initial begin
    d = 64'($urandom(92864));
    repeat (8) @(negedge CORE_CLK);
    NRST = 1;
    check("flt_rst", 64'(flt), 64'h1);
    acc(PLC_EL3, 1, 0, PLC_TOP_RST, PLC_ACC_DONE, PLC_EL3, 1);
    acc(PLC_EL3, 0, 0, PLC_HYP_RST, PLC_ACC_DONE, PLC_EL3, 1);
    for (int i = 0; i < 3; i++) acc(plc_el_t'(i), 1, 0, 0, PLC_ACC_UNDEF, PLC_EL3, 0);
    d = {$urandom, $urandom};
    acc(PLC_EL3, 1, 1, d, PLC_ACC_DONE, PLC_EL3, 0);
    acc(PLC_EL3, 1, 0, d & PLC_TOP_MASK, PLC_ACC_DONE, PLC_EL3, 1);
    check("fields", 64'({lbl.data_monitor_group, lbl.instr_monitor_group,
      lbl.data_partition_id, lbl.instr_partition_id}), {16'h0, d[47:0]});
    // memory side must have seen the new label without any maintenance step
    check("sink", 64'(sink_chg), 64'h1);
    ctx.root_state = 1;
    for (int i = 0; i < 4; i++) begin
      acc(PLC_EL3, 1, 1, (64'(i / 2) << PLC_ALT_SEL_BIT) | (64'(i % 2) << PLC_ROOT_NS_BIT),
          PLC_ACC_DONE, PLC_EL3, 0);
      repeat (2) @(negedge CORE_CLK);
      check("space", 64'(lbl.space), 64'(i > 1 ? 2 + i % 2 : 0));
    end
    cur_el = PLC_EL1;
    repeat (2) @(negedge CORE_CLK);
    check("space_nonroot", 64'(lbl.space), 64'(PLC_SPACE_ALT));
    check("flt_clr", 64'(flt), 64'h0);
    ctx.el2_enabled = 1;
    ctx.nv = 1;
    ctx.nv2 = 1;
    acc(PLC_EL1, 0, 0, 0, PLC_ACC_NVMEM, PLC_EL3, 0);
    ctx.nv2 = 0;
    acc(PLC_EL1, 0, 0, 0, PLC_ACC_TRAP, PLC_EL2, 0);
    ctx.nv = 0;
    acc(PLC_EL1, 0, 0, 0, PLC_ACC_UNDEF, PLC_EL3, 0);
    acc(PLC_EL0, 0, 0, 0, PLC_ACC_UNDEF, PLC_EL3, 0);
    acc(PLC_EL2, 0, 1, '1, PLC_ACC_DONE, PLC_EL3, 0);
    acc(PLC_EL2, 0, 0, PLC_HYP_MASK, PLC_ACC_DONE, PLC_EL3, 1);
    cur_el = PLC_EL0;
    for (int i = 0; i < 3; i++) begin
      ctx.trap_general_exceptions = i > 0;
      ctx.e2h = i == 1;
      repeat (2) @(negedge CORE_CLK);
      check("steer", 64'(steer), 64'(i == 0 ? 4'hD : (i == 1 ? 4'h1 : 4'h3)));
    end
    cur_el = PLC_EL1;
    repeat (2) @(negedge CORE_CLK);
    check("steer_l1", 64'(steer), 64'h5);
    ctx.el2_enabled = 0;
    repeat (2) @(negedge CORE_CLK);
    check("steer_off", 64'(steer), 64'h0);
    ctx.el2_enabled = 1;
    acc(PLC_EL3, 1, 1, 64'h4000_0000_0000_0000, PLC_ACC_DONE, PLC_EL3, 0);
    acc(PLC_EL2, 0, 0, 0, PLC_ACC_TRAP, PLC_EL3, 0);
    ctx.halted = 1;
    ctx.secure_debug_disable = 1;
    acc(PLC_EL2, 0, 0, 0, PLC_ACC_UNDEF, PLC_EL3, 0);
    HAVE_EL3 = 0;
    acc(PLC_EL2, 0, 0, PLC_HYP_MASK, PLC_ACC_DONE, PLC_EL3, 1);
    check("flt_noel3", 64'(flt), 64'h0);
    VIRT_SUPPORT_FLAG = 0;
    acc(PLC_EL3, 0, 0, 0, PLC_ACC_UNDEF, PLC_EL3, 0);
    repeat (3) @(negedge CORE_CLK);
    check("pending", 64'(expq.size()), 64'h0);
    final_report();
  end
endmodule : tb_plc_regs
